// ### core/wsc_top.v
`include "wsc_defs.vh"
`default_nettype none

// Contract
// - With the FIFO gate clear, every WAKE/SLEEP mode change flushes the sample FIFO.
// - With the FIFO gate set, a mode change keeps the FIFO and new samples are dropped until the host empties it.
// - With the gate set, a sample arriving after a mode change while the FIFO is still not empty raises the gate error.
// - The gate error stays high while the FIFO stays un-emptied and drops once the host empties it.
// - The transient function can wake the system only when its wake control is 1; otherwise it is bypassed in SLEEP.
// - The orientation function can wake the system only when its wake control is 1; otherwise it is bypassed in SLEEP.
// - The pulse function can wake the system only when its wake control is 1; otherwise it is bypassed in SLEEP.
// - The fall or motion function can wake the system only when its wake control is 1; otherwise it is bypassed in SLEEP.
// - The level select makes both interrupt pins active low at 0 and active high at 1.
// - The drive select makes both interrupt pins push-pull at 0 and open-drain at 1.
module wsc_top (
    // Every flop of the block stands still while ce is low.
    input  wire                     clk,
    input  wire                     rst_n,
    input  wire                     ce,

    // The register port moves one byte per strobe.
    input  wire [`WSC_ADDR_W-1:0]   reg_addr,
    input  wire [`WSC_DATA_W-1:0]   reg_wdata,
    input  wire                     reg_we,
    input  wire                     reg_re,
    output reg  [`WSC_DATA_W-1:0]   reg_rdata,

    // The mode logic talks to the four detection functions here.
    input  wire                     sleep_request,
    input  wire                     transient_irq,
    input  wire                     orientation_irq,
    input  wire                     pulse_irq,
    input  wire                     fall_motion_irq,
    output wire                     transient_run,
    output wire                     orientation_run,
    output wire                     pulse_run,
    output wire                     fall_motion_run,

    // The FIFO itself lives outside; only its controls pass here.
    input  wire                     sample_tick,
    input  wire                     fifo_empty,
    output reg                      fifo_flush,
    output wire                     fifo_sample_write,
    output reg                      fifo_gate_hold,
    output reg                      buffer_hold_error,
    output reg                      system_mode_status,
    output reg                      wake_event,

    // Each pad turns an internal request into a pin level.
    input  wire                     irq_pin_one_req,
    input  wire                     irq_pin_two_req,
    output wire                     irq_pin_one_out,
    output wire                     irq_pin_one_oe,
    output wire                     irq_pin_two_out,
    output wire                     irq_pin_two_oe
);

    // ************************************************************
    // Configuration register
    // ************************************************************
    reg  [`WSC_DATA_W-1:0] wake_and_pin_config;
    reg  [`WSC_DATA_W-1:0] read_value;
    wire                   cfg_hit;
    wire                   cfg_write;
    wire                   cfg_read;

    assign cfg_hit   = (reg_addr == `WSC_CFG_OFFSET);
    assign cfg_write = ce & reg_we & cfg_hit;
    assign cfg_read  = ce & reg_re;

    // Bit 2 is reserved: it is never stored and reads as zero.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_and_pin_config <= `WSC_CFG_RESET;
        end else if (cfg_write) begin
            wake_and_pin_config <= reg_wdata & `WSC_CFG_WRITE_MASK;
        end
    end

    // Offsets other than this register read as zero, so a host
    // scanning the map sees no ghost values.
    always @* begin
        if (cfg_hit) begin
            read_value = wake_and_pin_config;
        end else begin
            read_value = `WSC_READ_UNMAPPED;
        end
    end

    // The data register only moves on a read and holds between reads.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `WSC_READ_UNMAPPED;
        end else if (cfg_read) begin
            reg_rdata <= read_value;
        end
    end

    // Field views of the register, one wire per control.
    wire fifo_gate_on;
    wire irq_level_select;
    wire irq_drive_select;
    wire transient_wakes_system;
    wire orientation_wakes_system;
    wire pulse_wakes_system;
    wire fall_or_motion_wakes_system;

    assign fifo_gate_on     = wake_and_pin_config[`WSC_BIT_FIFO_GATE];
    assign irq_level_select = wake_and_pin_config[`WSC_BIT_IRQ_LEVEL];
    assign irq_drive_select = wake_and_pin_config[`WSC_BIT_IRQ_DRIVE];
    assign transient_wakes_system =
        wake_and_pin_config[`WSC_BIT_WAKE_TRANSIENT];
    assign orientation_wakes_system =
        wake_and_pin_config[`WSC_BIT_WAKE_ORIENT];
    assign pulse_wakes_system =
        wake_and_pin_config[`WSC_BIT_WAKE_PULSE];
    assign fall_or_motion_wakes_system =
        wake_and_pin_config[`WSC_BIT_WAKE_FALL];

    // ************************************************************
    // Wake source gating
    // ************************************************************
    wire [`WSC_NUM_SOURCES-1:0] src_allowed;
    wire [`WSC_NUM_SOURCES-1:0] src_irq;
    wire [`WSC_NUM_SOURCES-1:0] src_run;
    wire [`WSC_NUM_SOURCES-1:0] src_hit;
    wire                        asleep;

    // Source bits follow the register, highest wake control first.
    localparam SRC_TRANSIENT   = 3;
    localparam SRC_ORIENTATION = 2;
    localparam SRC_PULSE       = 1;
    localparam SRC_FALL_MOTION = 0;

    assign asleep = (system_mode_status == `WSC_MODE_SLEEP);

    assign src_allowed = {transient_wakes_system,
                          orientation_wakes_system,
                          pulse_wakes_system,
                          fall_or_motion_wakes_system};
    assign src_irq[SRC_TRANSIENT]   = transient_irq;
    assign src_irq[SRC_ORIENTATION] = orientation_irq;
    assign src_irq[SRC_PULSE]       = pulse_irq;
    assign src_irq[SRC_FALL_MOTION] = fall_motion_irq;

    // One gate module per function keeps the four paths alike.
    genvar gi;
    generate
        for (gi = 0; gi < `WSC_NUM_SOURCES; gi = gi + 1) begin : g_src
            wsc_src_gate u_gate (
                .clk          (clk),
                .rst_n        (rst_n),
                .ce           (ce),
                .wake_allowed (src_allowed[gi]),
                .asleep       (asleep),
                .func_irq     (src_irq[gi]),
                .func_run     (src_run[gi]),
                .wake_hit     (src_hit[gi])
            );
        end
    endgenerate

    assign transient_run   = src_run[SRC_TRANSIENT];
    assign orientation_run = src_run[SRC_ORIENTATION];
    assign pulse_run       = src_run[SRC_PULSE];
    assign fall_motion_run = src_run[SRC_FALL_MOTION];

    // ************************************************************
    // System mode
    // ************************************************************
    localparam ST_WAKE  = 1'b0;
    localparam ST_SLEEP = 1'b1;

    reg  next_mode;
    reg  next_wake_event;
    wire mode_change;
    wire any_hit;

    assign any_hit = |src_hit;

    // A wake hit is only ever produced by an allowed source in SLEEP.
    // The hit is registered, so the mode moves two edges after the
    // interrupt; a one-cycle interrupt pulse still wakes the system.
    // A sleep request while already asleep is ignored, not queued.
    always @* begin
        next_mode       = system_mode_status;
        next_wake_event = 1'b0;
        case (system_mode_status)
            ST_WAKE: begin
                if (sleep_request) begin
                    next_mode = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (any_hit) begin
                    next_mode       = ST_WAKE;
                    next_wake_event = 1'b1;
                end
            end
            default: begin
                next_mode = ST_WAKE;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            system_mode_status <= ST_WAKE;
            wake_event         <= 1'b0;
        end else if (ce) begin
            system_mode_status <= next_mode;
            wake_event         <= next_wake_event;
        end
    end

    assign mode_change = (next_mode != system_mode_status);

    // ************************************************************
    // FIFO gate and gate error
    // ************************************************************
    // The hold opens as soon as the FIFO is seen empty; a change that
    // finds it already empty therefore blocks nothing.
    reg  next_hold;
    reg  next_error;
    wire hold_arm;
    wire error_set;
    wire flush_due;

    assign hold_arm  = mode_change & fifo_gate_on & ~fifo_empty;
    assign error_set = fifo_gate_hold & sample_tick & ~fifo_empty;
    assign flush_due = mode_change & ~fifo_gate_on;

    always @* begin
        next_hold = fifo_gate_hold;
        if (fifo_empty) begin
            next_hold = 1'b0;
        end
        if (hold_arm) begin
            next_hold = 1'b1;
        end
    end

    // A sample that meets a held, non-empty FIFO wins over the clear.
    always @* begin
        next_error = buffer_hold_error;
        if (fifo_empty) begin
            next_error = 1'b0;
        end
        if (error_set) begin
            next_error = 1'b1;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_gate_hold    <= 1'b0;
            buffer_hold_error <= 1'b0;
            fifo_flush        <= 1'b0;
        end else if (ce) begin
            fifo_gate_hold    <= next_hold;
            buffer_hold_error <= next_error;
            fifo_flush        <= flush_due;
        end
    end

    // ************************************************************
    // Sample path
    // ************************************************************
    // Samples are dropped while the hold stands. With the gate clear no
    // hold ever forms and the flush pulse alone empties the FIFO.
    assign fifo_sample_write = ce & sample_tick & ~fifo_gate_hold;

    // ************************************************************
    // Interrupt pads
    // ************************************************************
    // Both pins share one level and one drive setting, so every source
    // on a shared open-drain line agrees on the asserted level.
    wsc_irq_pad u_pad_one (
        .clk        (clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .irq_req    (irq_pin_one_req),
        .level_high (irq_level_select),
        .open_drain (irq_drive_select),
        .pad_out    (irq_pin_one_out),
        .pad_oe     (irq_pin_one_oe)
    );

    wsc_irq_pad u_pad_two (
        .clk        (clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .irq_req    (irq_pin_two_req),
        .level_high (irq_level_select),
        .open_drain (irq_drive_select),
        .pad_out    (irq_pin_two_out),
        .pad_oe     (irq_pin_two_oe)
    );

endmodule

`default_nettype wire

// ### core/wsc_defs.vh
`ifndef WSC_DEFS_VH
`define WSC_DEFS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define WSC_ADDR_W              8
`define WSC_DATA_W              8
`define WSC_CFG_OFFSET          8'h2c
`define WSC_CFG_RESET           8'h00
`define WSC_CFG_WRITE_MASK      8'hfb
`define WSC_READ_UNMAPPED       8'h00

// ****************************************************************
// Field positions of wake_and_pin_config
// ****************************************************************
`define WSC_BIT_FIFO_GATE       7
`define WSC_BIT_WAKE_TRANSIENT  6
`define WSC_BIT_WAKE_ORIENT     5
`define WSC_BIT_WAKE_PULSE      4
`define WSC_BIT_WAKE_FALL       3
`define WSC_BIT_IRQ_LEVEL       1
`define WSC_BIT_IRQ_DRIVE       0

// ****************************************************************
// System modes and wake source count
// ****************************************************************
`define WSC_MODE_WAKE           1'b0
`define WSC_MODE_SLEEP          1'b1
`define WSC_NUM_SOURCES         4

`endif

// ### core/wsc_src_gate.v
`default_nettype none

// ****************************************************************
// One detection function seen by the wake logic
// ****************************************************************
// In SLEEP a function whose wake control is clear is bypassed: it is
// not clocked forward and its interrupt can never wake the system.
module wsc_src_gate (
    input  wire clk,
    input  wire rst_n,
    input  wire ce,
    input  wire wake_allowed,
    input  wire asleep,
    input  wire func_irq,
    output reg  func_run,
    output reg  wake_hit
);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            func_run <= 1'b1;
            wake_hit <= 1'b0;
        end else if (ce) begin
            func_run <= ~asleep | wake_allowed;
            wake_hit <= asleep & wake_allowed & func_irq;
        end
    end

endmodule

`default_nettype wire

// ### core/wsc_irq_pad.v
`default_nettype none

// ****************************************************************
// Interrupt pad driver
// ****************************************************************
// Open-drain can only pull low, so in that mode the pad is released
// whenever the wanted level is high and an outside pull-up sets it.
module wsc_irq_pad (
    input  wire clk,
    input  wire rst_n,
    input  wire ce,
    input  wire irq_req,
    input  wire level_high,
    input  wire open_drain,
    output reg  pad_out,
    output reg  pad_oe
);

    reg level;

    always @* begin
        level = level_high ? irq_req : ~irq_req;
    end

    // Reset shows a push-pull, active-low, idle pad: driven high.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out <= 1'b1;
            pad_oe  <= 1'b1;
        end else if (ce) begin
            if (open_drain) begin
                pad_out <= 1'b0;
                pad_oe  <= ~level;
            end else begin
                pad_out <= level;
                pad_oe  <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ### dv/wsc_checker.sv
`default_nettype none
module wsc_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic sample_tick,
    input wire logic fifo_empty,
    input wire logic fifo_flush,
    input wire logic fifo_sample_write,
    input wire logic fifo_gate_hold,
    input wire logic buffer_hold_error,
    input wire logic system_mode_status,
    input wire logic wake_event,
    input wire logic transient_irq,
    input wire logic orientation_irq,
    input wire logic pulse_irq,
    input wire logic fall_motion_irq,
    input wire logic transient_run,
    input wire logic orientation_run,
    input wire logic pulse_run,
    input wire logic fall_motion_run,
    input wire logic irq_pin_one_out,
    input wire logic irq_pin_one_oe,
    input wire logic irq_pin_two_out,
    input wire logic irq_pin_two_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    wire live;
    // A bypassed function shows run low from its second SLEEP cycle on, so only from then can it not count as live.
    assign live = system_mode_status & |({transient_irq, orientation_irq,
        pulse_irq, fall_motion_irq} & {transient_run, orientation_run,
        pulse_run, fall_motion_run});
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_live;
        ce && system_mode_status && $past(system_mode_status) && live;
    endsequence
    sequence s_woken;
        ##[1:2] (!system_mode_status && wake_event);
    endsequence
    AST_WAKE_FWD: assert property (s_live |-> s_woken)
        else $error("enabled source did not wake");
    AST_WAKE_CAUSE: assert property ($fell(system_mode_status) |->
        wake_event && $past(live, 2)) else $error("wake without source");
    AST_FLUSH: assert property (fifo_flush |->
        $changed(system_mode_status)) else $error("flush off mode change");
    AST_HOLD: assert property ($rose(fifo_gate_hold) |->
        $changed(system_mode_status) && !fifo_flush)
        else $error("hold off mode change");
    AST_BLOCK: assert property (fifo_gate_hold |->
        !fifo_sample_write) else $error("sample passed while held");
    AST_ERR_SET: assert property (ce && sample_tick && fifo_gate_hold &&
        !fifo_empty |=> buffer_hold_error) else $error("gate error missed");
    AST_ERR_CLR: assert property (ce && fifo_empty |=>
        !buffer_hold_error) else $error("gate error not cleared");
    AST_ERR_CAUSE: assert property ($rose(buffer_hold_error) |->
        $past(fifo_gate_hold) && $past(sample_tick))
        else $error("gate error without cause");
    AST_PAD: assert property (!irq_pin_one_oe |->
        !irq_pin_one_out) else $error("released pad drives high");
    AST_PAD_TWO: assert property (!irq_pin_two_oe |->
        !irq_pin_two_out) else $error("released pad two drives high");
endmodule
bind wsc_top wsc_checker u_chk (.*);
`default_nettype wire

// ### dv/wsc_host_model.sv
`default_nettype none
module wsc_host_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       fifo_flush,
    input  wire logic       fifo_sample_write,
    input  wire logic       drain,
    input  wire logic [1:0] pout,
    input  wire logic [1:0] poe,
    output wire logic       fifo_empty,
    output wire logic [1:0] line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] count;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 6'h03;
        end else if (fifo_flush || drain) begin
            count <= 6'h00;
        end else if (fifo_sample_write && count < 6'h20) begin
            count <= count + 6'h01;
        end
    end
    assign fifo_empty = (count == 6'h00);
    // A pull-up holds a line high whenever its pad lets go of it.
    assign line[0] = poe[0] ? pout[0] : 1'b1;
    assign line[1] = poe[1] ? pout[1] : 1'b1;
endmodule
`default_nettype wire

// ### dv/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, rst_n = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic       sleep_request = 1'b0, sample_tick = 1'b0, drain = 1'b0;
    logic       ce = 1'b1;
    logic [3:0] irq = 4'h0;
    logic [1:0] req = 2'h0;
    wire  [7:0] reg_rdata;
    wire  [3:0] run;
    wire  [1:0] pout, poe, line;
    wire        fifo_empty, fifo_flush, fifo_sample_write, fifo_gate_hold;
    wire        buffer_hold_error, system_mode_status, wake_event;
    int         mismatches = 0, n_tests = 0;
    always #5 clk = ~clk;
    wsc_top u_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata),
        .sleep_request(sleep_request), .transient_irq(irq[0]),
        .orientation_irq(irq[1]), .pulse_irq(irq[2]),
        .fall_motion_irq(irq[3]), .transient_run(run[0]),
        .orientation_run(run[1]), .pulse_run(run[2]),
        .fall_motion_run(run[3]), .sample_tick(sample_tick),
        .fifo_empty(fifo_empty), .fifo_flush(fifo_flush),
        .fifo_sample_write(fifo_sample_write),
        .fifo_gate_hold(fifo_gate_hold),
        .buffer_hold_error(buffer_hold_error),
        .system_mode_status(system_mode_status), .wake_event(wake_event),
        .irq_pin_one_req(req[0]), .irq_pin_two_req(req[1]),
        .irq_pin_one_out(pout[0]), .irq_pin_one_oe(poe[0]),
        .irq_pin_two_out(pout[1]), .irq_pin_two_oe(poe[1]));
    wsc_host_model u_host (.clk(clk), .rst_n(rst_n), .fifo_flush(fifo_flush),
        .fifo_sample_write(fifo_sample_write), .drain(drain), .pout(pout),
        .poe(poe), .fifo_empty(fifo_empty), .line(line));
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) {reg_addr, reg_wdata, reg_we} <= {a, d, 1'b1};
        @(posedge clk) reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) {reg_addr, reg_re} <= {a, 1'b1};
        @(posedge clk) reg_re <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, e);
    endtask
    // Bounded wait; a mode that never arrives ends the run at once.
    task automatic wait_mode(input logic m);
        @(negedge clk);
        for (int k = 0; k < 8 && system_mode_status !== m; k++) @(negedge clk);
        if (system_mode_status !== m) begin
            mismatches++;
            $display("[ERR] %0t mode change missing", $time);
            test_done();
        end
    endtask
    task automatic go_sleep();
        @(posedge clk) sleep_request <= 1'b1;
        @(posedge clk) sleep_request <= 1'b0;
        wait_mode(1'b1);
    endtask
    task automatic t_reg();
        rd(8'h2c, 8'h00);
        wr(8'h2c, 8'hff);
        rd(8'h2c, 8'hfb);
        wr(8'h2d, 8'h5a);
        rd(8'h2d, 8'h00);
        rd(8'h2c, 8'hfb);
        // A write while the enable is low must not land.
        @(posedge clk) ce <= 1'b0;
        wr(8'h2c, 8'h00);
        @(posedge clk) ce <= 1'b1;
        rd(8'h2c, 8'hfb);
        $display("test reg done");
    endtask
    task automatic t_pads();
        logic l;
        for (int c = 0; c < 4; c++) begin
            wr(8'h2c, c[7:0]);
            for (int r = 0; r < 2; r++) begin
                @(posedge clk) req <= {~r[0], r[0]};
                repeat (2) @(negedge clk);
                l = c[1] ? r[0] : ~r[0];
                chk({pout[0], poe[0], line}, {~c[0] & l, ~c[0] | ~l, ~l, l});
            end
        end
        $display("test pads done");
    endtask
    task automatic t_wake();
        logic [3:0] en;
        for (int i = 0; i < 4; i++) begin
            en = 4'h1 << i;
            wr(8'h2c, {1'b0, en[0], en[1], en[2], en[3], 3'h0});
            go_sleep();
            chk({7'h0, fifo_flush}, 8'h01);
            repeat (3) @(negedge clk);
            chk({4'h0, run}, {4'h0, en});
            @(posedge clk) irq <= ~en;
            repeat (6) @(negedge clk);
            chk({7'h0, system_mode_status}, 8'h01);
            @(posedge clk) irq <= 4'hf;
            wait_mode(1'b0);
            chk({6'h0, fifo_flush, wake_event}, 8'h03);
            @(posedge clk) irq <= 4'h0;
        end
        $display("test wake done");
    endtask
    task automatic t_gate();
        wr(8'h2c, 8'h80);
        @(posedge clk) sample_tick <= 1'b1;
        @(posedge clk) sample_tick <= 1'b0;
        go_sleep();
        chk({6'h0, fifo_flush, fifo_gate_hold}, 8'h01);
        @(posedge clk) sample_tick <= 1'b1;
        @(negedge clk);
        chk({7'h0, fifo_sample_write}, 8'h00);
        @(posedge clk) sample_tick <= 1'b0;
        repeat (2) @(negedge clk);
        chk({6'h0, fifo_gate_hold, buffer_hold_error}, 8'h03);
        @(posedge clk) drain <= 1'b1;
        @(posedge clk) drain <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk({6'h0, fifo_gate_hold, buffer_hold_error}, 8'h00);
        @(posedge clk) sample_tick <= 1'b1;
        @(negedge clk);
        chk({7'h0, fifo_sample_write}, 8'h01);
        @(posedge clk) sample_tick <= 1'b0;
        $display("test gate done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reg();
        t_pads();
        t_wake();
        t_gate();
        test_done();
    end
endmodule
`default_nettype wire
